// File: shared/bhr_pkg.sv
package bhr_pkg;

    // Clock and serial PROM timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SK_HALF_NS = 500;
    localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SK_HALF_LAST = 8'(SK_HALF_CYC - 1);
    localparam logic [1:0] STRAP_SETTLE_LAST = 2'h3;

    // Bank pointer
    localparam int NUM_BANKS = 64;
    localparam logic [5:0] BANK_ZERO = 6'h00;

    // Register offsets within the 16-byte window
    localparam logic [3:0] OFS_BASE = 4'h0;
    localparam logic [3:0] OFS_WMARK = 4'h4;
    localparam logic [3:0] OFS_BUSERR = 4'h6;
    localparam logic [3:0] OFS_BANK_DW = 4'hC;
    localparam logic [3:0] OFS_BANK = 4'hE;

    // Reset values and writable masks
    localparam logic [15:0] BASE_RST = 16'h0300;
    localparam logic [15:0] BASE_MASK = 16'hFFE0;
    localparam logic [15:0] WMARK_RST = 16'h0000;
    localparam logic [15:0] WMARK_MASK = 16'h1000;
    localparam logic [15:0] BANK_RST = 16'h0000;
    localparam logic [15:0] BANK_MASK = 16'h003F;
    localparam logic [15:0] BUSERR_RST = 16'h0000;

    // Field positions
    localparam int WMARK_BIT = 12;
    localparam int BUSERR_FLAG_BIT = 15;
    localparam int BUSERR_VAL_LSB = 11;

    // Serial PROM read of word 0: start bit, read opcode, 6-bit address
    localparam logic [5:0] PROM_WORD_ADDR = 6'h00;
    localparam logic [2:0] PROM_READ_OP = 3'h6;
    localparam logic [4:0] PROM_CMD_BITS = 5'h09;
    localparam logic [4:0] PROM_DATA_FIRST = 5'h0A;
    localparam logic [4:0] PROM_LAST_BIT = 5'h19;

    typedef struct packed {
        logic [15:0] addr;
        logic [3:0] be;
        logic rd;
        logic wr;
        logic [31:0] wdata;
    } bhr_host_req_t;

    typedef enum logic [3:0] {
        ST_WAIT = 4'h1,
        ST_LOW = 4'h2,
        ST_HIGH = 4'h4,
        ST_DONE = 4'h8
    } bhr_prom_state_t;

endpackage

// File: src/bhr_top.sv
`timescale 1ns/100ps

// Overview of operation
// - A 6-bit bank pointer, reset zero, picks one of 64 register banks.
// - Bank pointer decodes at offset 0xE whatever bank is selected.
// - A 32-bit write at 0xC leaves byte lanes 0xC and 0xD untouched.
// - With the PROM strap low, base address resets to 0x300.
// - With the PROM strap high, base address loads from PROM word 0 after reset.
// - Host may rewrite base address; the PROM is never written back.
// - Base bits 15..8 are compared with host address 15..8.
// - Base bits 7..5 compared with address 7..5; base bits 4..0 read zero.
// - Bank 0 watermark bit 12, reset zero: 0 gives 3 KB, 1 gives 2 KB.
// - Write-one-to-clear flag clears on a written one, holds on a zero; an illegal enable in that same write sets it instead.
// - Without a PROM the base stays at its default; software sets the MAC.
module bhr_top (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Host bus, synchronous to CLOCK
    input wire logic [15:0] HOST_ADDR,
    input wire logic [3:0] HOST_BE,
    input wire logic HOST_RD,
    input wire logic HOST_WR,
    input wire logic [31:0] HOST_WDATA,
    output logic [31:0] HOST_RDATA,
    output logic HOST_RVALID,
    // Strap and serial PROM pins
    input wire logic PROM_LOAD_STRAP,
    input wire logic PROM_DO,
    output logic PROM_CS,
    output logic PROM_SK,
    output logic PROM_DI,
    // Block status
    output logic [5:0] BANK_SEL,
    output logic RX_WMARK_2K,
    output logic PROM_BUSY
);

    bhr_pkg::bhr_host_req_t req;

    logic [15:0] base_reg, base_next;
    logic [15:0] wmark_reg, wmark_next;
    logic [15:0] bank_reg, bank_next;
    logic [15:0] buserr_reg, buserr_next;
    logic [31:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;

    bhr_pkg::bhr_prom_state_t st_reg, st_next;
    logic [7:0] tick_reg, tick_next;
    logic [4:0] bit_reg, bit_next;
    logic [15:0] shift_reg, shift_next;
    logic [1:0] settle_reg, settle_next;
    logic cs_reg, cs_next;
    logic sk_reg, sk_next;
    logic di_reg, di_next;

    logic strap_meta_reg, strap_sync_reg;
    logic do_meta_reg, do_sync_reg;

    logic hit;
    logic bank0;
    logic [1:0] word_sel;
    logic legal_be;
    logic [8:0] prom_cmd;
    logic prom_load;

    assign req = '{addr: HOST_ADDR, be: HOST_BE, rd: HOST_RD, wr: HOST_WR, wdata: HOST_WDATA};

    // Lane-wise merge keeping unwritable bits at zero
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [15:0] data,
                                               input logic [1:0] be,
                                               input logic [15:0] mask);
        logic [15:0] res;
        res = old;
        if (be[0])
        begin
            res[7:0] = data[7:0];
        end
        if (be[1])
        begin
            res[15:8] = data[15:8];
        end
        return res & mask;
    endfunction

    always_comb
    begin
        // 4-bit base window: base bits 4..0 are zero so address bit 4 must be zero
        hit = (req.addr[15:8] == base_reg[15:8])
              && (req.addr[7:5] == base_reg[7:5])
              && !req.addr[4];
        bank0 = (bank_reg[5:0] == bhr_pkg::BANK_ZERO);
        word_sel = req.addr[3:2];
        case (req.be)
            4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF: legal_be = 1'b1;
            default: legal_be = 1'b0;
        endcase
        prom_cmd = {bhr_pkg::PROM_READ_OP, bhr_pkg::PROM_WORD_ADDR};
        prom_load = (st_reg == bhr_pkg::ST_HIGH) && (tick_reg == bhr_pkg::SK_HALF_LAST)
                    && (bit_reg == bhr_pkg::PROM_LAST_BIT);
    end

    // Host register file
    always_comb
    begin
        base_next = base_reg;
        wmark_next = wmark_reg;
        bank_next = bank_reg;
        buserr_next = buserr_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        if (req.wr && hit)
        begin
            // Bank pointer lives in every bank; lanes 0 and 1 of this word hold nothing
            if (word_sel == bhr_pkg::OFS_BANK_DW[3:2])
            begin
                bank_next = lane_merge(bank_reg, req.wdata[31:16], req.be[3:2],
                                       bhr_pkg::BANK_MASK);
            end
            if (bank0 && word_sel == bhr_pkg::OFS_BASE[3:2])
            begin
                // Internal copy only; nothing goes back to the PROM
                base_next = lane_merge(base_reg, req.wdata[15:0], req.be[1:0],
                                       bhr_pkg::BASE_MASK);
            end
            if (bank0 && word_sel == bhr_pkg::OFS_WMARK[3:2])
            begin
                wmark_next = lane_merge(wmark_reg, req.wdata[15:0], req.be[1:0],
                                        bhr_pkg::WMARK_MASK);
                if (req.be[3] && req.wdata[16 + bhr_pkg::BUSERR_FLAG_BIT])
                begin
                    buserr_next[bhr_pkg::BUSERR_FLAG_BIT] = 1'b0;
                end
            end
        end
        // A fresh illegal enable beats a clear in the same cycle
        if ((req.wr || req.rd) && hit && !legal_be)
        begin
            buserr_next[bhr_pkg::BUSERR_FLAG_BIT] = 1'b1;
            buserr_next[bhr_pkg::BUSERR_VAL_LSB +: 4] = req.be;
        end
        if (prom_load)
        begin
            // Last data bit joins here; shift_reg alone is still one bit short
            base_next = {shift_reg[14:0], do_sync_reg} & bhr_pkg::BASE_MASK;
        end
        if (req.rd && hit)
        begin
            rvalid_next = 1'b1;
            rdata_next = 32'h0000_0000;
            case (word_sel)
                bhr_pkg::OFS_BASE[3:2]:
                    if (bank0)
                    begin
                        rdata_next = {16'h0000, base_reg};
                    end
                bhr_pkg::OFS_WMARK[3:2]:
                    if (bank0)
                    begin
                        rdata_next = {buserr_reg, wmark_reg};
                    end
                bhr_pkg::OFS_BANK_DW[3:2]:
                    rdata_next = {bank_reg, 16'h0000};
                default:
                    rdata_next = 32'h0000_0000;
            endcase
        end
        if (!RST_N)
        begin
            base_next = bhr_pkg::BASE_RST;
            wmark_next = bhr_pkg::WMARK_RST;
            bank_next = bhr_pkg::BANK_RST;
            buserr_next = bhr_pkg::BUSERR_RST;
            rdata_next = 32'h0000_0000;
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        base_reg <= base_next;
        wmark_reg <= wmark_next;
        bank_reg <= bank_next;
        buserr_reg <= buserr_next;
        rdata_reg <= rdata_next;
        rvalid_reg <= rvalid_next;
    end

    // Pin synchronisers
    always_ff @(posedge CLOCK)
    begin
        strap_meta_reg <= PROM_LOAD_STRAP;
        strap_sync_reg <= strap_meta_reg;
        do_meta_reg <= PROM_DO;
        do_sync_reg <= do_meta_reg;
    end

    // Serial PROM reader: with the strap high, one read of word 0 after reset, then idle forever
    always_comb
    begin
        st_next = st_reg;
        tick_next = tick_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        settle_next = settle_reg;
        cs_next = cs_reg;
        sk_next = sk_reg;
        di_next = di_reg;
        case (st_reg)
            bhr_pkg::ST_WAIT:
            begin
                // Let the strap pass its synchroniser before deciding
                settle_next = settle_reg + 2'h1;
                if (settle_reg == bhr_pkg::STRAP_SETTLE_LAST)
                begin
                    if (strap_sync_reg)
                    begin
                        st_next = bhr_pkg::ST_LOW;
                        cs_next = 1'b1;
                        di_next = prom_cmd[8];
                    end
                    else
                    begin
                        st_next = bhr_pkg::ST_DONE;
                    end
                end
            end
            bhr_pkg::ST_LOW:
            begin
                tick_next = tick_reg + 8'h01;
                if (tick_reg == bhr_pkg::SK_HALF_LAST)
                begin
                    tick_next = 8'h00;
                    sk_next = 1'b1;
                    st_next = bhr_pkg::ST_HIGH;
                end
            end
            bhr_pkg::ST_HIGH:
            begin
                tick_next = tick_reg + 8'h01;
                if (tick_reg == bhr_pkg::SK_HALF_LAST)
                begin
                    tick_next = 8'h00;
                    sk_next = 1'b0;
                    // Sampled late in the high phase to cover synchroniser delay
                    if (bit_reg >= bhr_pkg::PROM_DATA_FIRST)
                    begin
                        shift_next = {shift_reg[14:0], do_sync_reg};
                    end
                    if (bit_reg == bhr_pkg::PROM_LAST_BIT)
                    begin
                        cs_next = 1'b0;
                        di_next = 1'b0;
                        st_next = bhr_pkg::ST_DONE;
                    end
                    else
                    begin
                        bit_next = bit_reg + 5'h01;
                        di_next = (bit_reg + 5'h01 < bhr_pkg::PROM_CMD_BITS)
                                  ? prom_cmd[4'(5'h08 - bit_reg - 5'h01)] : 1'b0;
                        st_next = bhr_pkg::ST_LOW;
                    end
                end
            end
            bhr_pkg::ST_DONE:
                st_next = bhr_pkg::ST_DONE;
            default:
                st_next = bhr_pkg::ST_DONE;
        endcase
        if (!RST_N)
        begin
            st_next = bhr_pkg::ST_WAIT;
            tick_next = 8'h00;
            bit_next = 5'h00;
            shift_next = 16'h0000;
            settle_next = 2'h0;
            cs_next = 1'b0;
            sk_next = 1'b0;
            di_next = 1'b0;
        end
    end

    always_ff @(posedge CLOCK)
    begin
        st_reg <= st_next;
        tick_reg <= tick_next;
        bit_reg <= bit_next;
        shift_reg <= shift_next;
        settle_reg <= settle_next;
        cs_reg <= cs_next;
        sk_reg <= sk_next;
        di_reg <= di_next;
    end

    assign HOST_RDATA = rdata_reg;
    assign HOST_RVALID = rvalid_reg;
    assign PROM_CS = cs_reg;
    assign PROM_SK = sk_reg;
    assign PROM_DI = di_reg;
    assign BANK_SEL = bank_reg[5:0];
    assign RX_WMARK_2K = wmark_reg[bhr_pkg::WMARK_BIT];
    assign PROM_BUSY = (st_reg != bhr_pkg::ST_DONE);

endmodule

// File: sim/bhr_prom_model.sv
`timescale 1ns/100ps
module bhr_prom_model #(
    parameter logic [15:0] WORD0 = 16'h0427
) (
    // Serial pins
    input wire logic cs,
    input wire logic sk,
    input wire logic di,
    output logic dout,
    // Command bits seen on di
    output logic [8:0] cmd
);
    logic [4:0] idx = 5'h00;
    initial dout = 1'b0;
    initial cmd = 9'h000;
    // Filler toggles so a stale level never looks like real data
    always @(posedge sk or negedge cs)
    begin
        if (!cs)
        begin
            idx <= 5'h00;
            dout <= ~dout;
        end
        else
        begin
            if (idx < 5'h09)
                cmd <= {cmd[7:0], di};
            dout <= (idx >= 5'h0A) ? WORD0[4'(5'h19 - idx)] : ~dout;
            idx <= idx + 5'h01;
        end
    end
endmodule

// File: sim/bhr_top_chk.sv
`timescale 1ns/100ps
module bhr_top_chk (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_N,
    // Host side
    input wire logic [3:0] HOST_BE,
    input wire logic HOST_RD,
    input wire logic HOST_WR,
    input wire logic [31:0] HOST_WDATA,
    input wire logic HOST_RVALID,
    // PROM and status
    input wire logic PROM_LOAD_STRAP,
    input wire logic PROM_CS,
    input wire logic PROM_SK,
    input wire logic PROM_DI,
    input wire logic [5:0] BANK_SEL,
    input wire logic RX_WMARK_2K,
    input wire logic PROM_BUSY
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    chk_bank_source: assert property ($changed(BANK_SEL) && $past(RST_N) |->
        $past(HOST_WR && HOST_BE[2]) && BANK_SEL == $past(HOST_WDATA[21:16]))
        else $error("bank pointer changed without a matching write");
    chk_wmark_source: assert property ($changed(RX_WMARK_2K) && $past(RST_N) |->
        $past(HOST_WR && HOST_BE[1]) && RX_WMARK_2K == $past(HOST_WDATA[12]))
        else $error("watermark changed without a matching write");
    chk_rvalid_cause: assert property (HOST_RVALID |-> $past(HOST_RD))
        else $error("read answer without a read");
    chk_reset_state: assert property ($rose(RST_N) |->
        BANK_SEL == 6'h00 && !RX_WMARK_2K && PROM_BUSY && !PROM_CS)
        else $error("wrong state after reset");
    chk_strap_low: assert property ($rose(RST_N) && !PROM_LOAD_STRAP |-> ##[3:8] !PROM_BUSY)
        else $error("strap low did not finish quickly");
    chk_frame_strap: assert property ($rose(PROM_CS) |-> PROM_LOAD_STRAP && PROM_BUSY)
        else $error("PROM frame without strap");
    chk_sk_high: assert property ($fell(PROM_SK) |-> $past(PROM_SK, 50) && !$past(PROM_SK, 51))
        else $error("serial clock high phase not 50 cycles");
    chk_di_hold: assert property (PROM_SK && $past(PROM_SK) |-> $stable(PROM_DI))
        else $error("PROM data in moved while clock high");
    chk_frame_end: assert property ($fell(PROM_CS) |-> !PROM_SK ##1 !PROM_BUSY)
        else $error("PROM frame end wrong");
    cover property ($fell(PROM_CS));
    cover property ($changed(BANK_SEL));
    cover property ($rose(RX_WMARK_2K));
endmodule
bind bhr_top bhr_top_chk bhr_top_chk_inst (.CLOCK(CLOCK), .RST_N(RST_N), .HOST_BE(HOST_BE),
    .HOST_RD(HOST_RD), .HOST_WR(HOST_WR), .HOST_WDATA(HOST_WDATA), .HOST_RVALID(HOST_RVALID),
    .PROM_LOAD_STRAP(PROM_LOAD_STRAP), .PROM_CS(PROM_CS), .PROM_SK(PROM_SK), .PROM_DI(PROM_DI),
    .BANK_SEL(BANK_SEL), .RX_WMARK_2K(RX_WMARK_2K), .PROM_BUSY(PROM_BUSY));

// File: sim/bhr_top_tb.sv
`timescale 1ns/100ps
module bhr_top_tb;
    typedef struct packed {
        logic w; logic [15:0] wa; logic [3:0] wb; logic [31:0] wd;
        logic [15:0] ra; logic [3:0] rb; logic ev; logic [31:0] ex;
    } bhr_row_t;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic strap = 1'b0;
    bhr_pkg::bhr_host_req_t req = '0;
    logic [31:0] rdata;
    logic rvalid, prom_do, prom_cs, prom_sk, prom_di, wmark, busy;
    logic [5:0] bank_sel;
    logic [8:0] cmd;
    int fails = 0;
    int samples_checked = 0;
    bhr_row_t rows [10] = '{
        '{1'b0, 16'h0, 4'h0, 32'h0, 16'h0300, 4'h3, 1'b1, 32'h0000_0300},
        '{1'b1, 16'h0304, 4'h3, 32'h0000_FFFF, 16'h0304, 4'h3, 1'b1, 32'h0000_1000},
        '{1'b1, 16'h0304, 4'h1, 32'h0, 16'h0304, 4'h3, 1'b1, 32'h0000_1000},
        '{1'b1, 16'h030C, 4'hF, 32'h0005_1234, 16'h030C, 4'hF, 1'b1, 32'h0005_0000},
        '{1'b1, 16'h0304, 4'h3, 32'h0, 16'h0304, 4'h3, 1'b1, 32'h0},
        '{1'b1, 16'h030E, 4'h4, 32'h0, 16'h030E, 4'hC, 1'b1, 32'h0},
        '{1'b0, 16'h0, 4'h0, 32'h0, 16'h0304, 4'h3, 1'b1, 32'h0000_1000},
        '{1'b1, 16'h0300, 4'h3, 32'h0000_045F, 16'h0440, 4'h3, 1'b1, 32'h0000_0440},
        '{1'b0, 16'h0, 4'h0, 32'h0, 16'h0300, 4'h3, 1'b0, 32'h0},
        '{1'b0, 16'h0, 4'h0, 32'h0, 16'h0460, 4'h3, 1'b0, 32'h0}
    };
    always #5 clock = ~clock;
    bhr_top bhr_top_inst (.CLOCK(clock), .RST_N(rst_n), .HOST_ADDR(req.addr), .HOST_BE(req.be),
        .HOST_RD(req.rd), .HOST_WR(req.wr), .HOST_WDATA(req.wdata), .HOST_RDATA(rdata),
        .HOST_RVALID(rvalid), .PROM_LOAD_STRAP(strap), .PROM_DO(prom_do), .PROM_CS(prom_cs),
        .PROM_SK(prom_sk), .PROM_DI(prom_di), .BANK_SEL(bank_sel), .RX_WMARK_2K(wmark),
        .PROM_BUSY(busy));
    bhr_prom_model bhr_prom_model_inst (.cs(prom_cs), .sk(prom_sk), .di(prom_di),
        .dout(prom_do), .cmd(cmd));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write cycle, then read cycle; answer looked at while its one-cycle valid stands
    task automatic xfer(input bhr_row_t t, input logic [31:0] mk = 32'hFFFF_FFFF);
        @(negedge clock);
        req = '{addr: t.wa, be: t.wb, rd: 1'b0, wr: t.w, wdata: t.wd};
        @(negedge clock);
        req = '{addr: t.ra, be: t.rb, rd: 1'b1, wr: 1'b0, wdata: 32'h0};
        @(negedge clock);
        check({31'h0, rvalid}, {31'h0, t.ev});
        if (t.ev)
            check(rdata & mk, t.ex);
        req.rd = 1'b0;
    endtask
    task automatic results;
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10000) @(posedge clock);
        fails++;
        results();
    end
    initial
    begin
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        foreach (rows[i])
            xfer(rows[i]);
        $display("table rows done");
        // Table left the base at 0x440
        xfer('{1'b1, 16'h0444, 4'h5, 32'h0, 16'h0444, 4'hC, 1'b1, 32'hA800_1000});
        xfer('{1'b1, 16'h0444, 4'h8, 32'h0, 16'h0444, 4'hC, 1'b1, 32'hA800_1000});
        xfer('{1'b1, 16'h0444, 4'h8, 32'h8000_0000, 16'h0444, 4'hC, 1'b1, 32'h0},
            32'h8000_0000);
        // Illegal enables and a clear in one write: the set must win
        xfer('{1'b1, 16'h0444, 4'h9, 32'h8000_0000, 16'h0444, 4'hC, 1'b1, 32'hC800_1000});
        // Watermark lanes 0 and 1 written back exactly as read
        xfer('{1'b1, 16'h0444, 4'h3, rdata, 16'h0444, 4'h3, 1'b1, 32'hC800_1000});
        $display("flag clear done");
        rst_n = 1'b0;
        strap = 1'b1;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        @(negedge clock);
        check({24'h0, bank_sel, wmark, busy}, {24'h0, 6'h00, 1'b0, 1'b1});
        // Host base write during the load takes effect, then the PROM word replaces it
        xfer('{1'b1, 16'h0300, 4'h3, 32'h0000_0600, 16'h0600, 4'h3, 1'b1, 32'h0000_0600});
        for (int i = 0; i < 4000 && busy !== 1'b0; i++)
            @(negedge clock);
        xfer('{1'b0, 16'h0, 4'h0, 32'h0, 16'h0420, 4'h3, 1'b1, 32'h0000_0420});
        check({23'h0, cmd}, {23'h0, 9'h180});
        $display("prom load done");
        results();
    end
endmodule
